// ==== rtl/keypad_event_encoder.sv ====
// keypad_event_encoder: scans a key matrix and plain input pins and
// emits coded press and release events to the key event queue
// assumes: pins are asynchronous, pulled up outside, keys pull rows low;
// queue, lock machine and register master share sys_clk
`timescale 1ns/1ps
`include "keypad_cfg.svh"
module keypad_event_encoder #(
   parameter int unsigned SLOT_CYC = `SCAN_SLOT_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic [17:0] pin_in,
   output logic      [17:0] pin_out,
   output logic      [17:0] pin_oe,
   input  wire logic        keypad_locked,
   input  wire logic        event_ready,
   output logic             event_valid,
   output logic      [7:0]  event_code,
   output logic             event_from_input,
   output logic             unlock_valid,
   output logic      [2:0]  unlock_time_s,
   output logic      [4:0]  mask_time_s
);

   localparam logic [`SLOT_CNT_W-1:0] SLOT_LAST =
      `SLOT_CNT_W'(SLOT_CYC - 1);

   // lowest set bit of a vector, all ones when none
   function automatic logic [4:0] first_set(input logic [17:0] vec);
      logic [4:0] idx;
      idx = 5'h1f;
      for (int i = 17; i >= 0; i--) begin
         if (vec[i]) idx = 5'(i);
      end
      return idx;
   endfunction : first_set

   ////////////////////////////////////////////////////////////////////////
   // pin synchroniser and event byte encoder

   logic [17:0] pin_lvl;
   logic [7:0]  code_w;
   logic        take_plain;
   logic        take_key;
   logic        press_w;
   logic [4:0]  plain_idx;
   logic [2:0]  key_row;
   logic [3:0]  col_q;

   pin_sync #(
      .WIDTH (`PIN_COUNT)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in (pin_in),
      .sync_out (pin_lvl)
   );

   key_code_encoder u_code (
      .from_input (take_plain),
      .pin_idx    (plain_idx),
      .row        (key_row),
      .col        (col_q),
      .press      (press_w),
      .code       (code_w)
   );

   ////////////////////////////////////////////////////////////////////////
   // configuration registers

   logic [1:0]  ctrl_q,  ctrl_d;
   logic [17:0] sel_q,   sel_d;
   logic [17:0] en_q,    en_d;
   logic [17:0] pol_q,   pol_d;
   logic [17:0] dir_q,   dir_d;
   logic [17:0] dout_q,  dout_d;
   logic [7:0]  tmr_q,   tmr_d;
   logic        scan_en;

   assign scan_en = ctrl_q[`CTRL_SCAN_EN];

   // software writes, one word per aligned offset
   always_comb begin
      ctrl_d = ctrl_q;
      sel_d  = sel_q;
      en_d   = en_q;
      pol_d  = pol_q;
      dir_d  = dir_q;
      dout_d = dout_q;
      tmr_d  = tmr_q;
      if (reg_wr) begin
         unique case (reg_addr)
            `REG_CTRL:       ctrl_d = reg_wdata[1:0];
            `REG_PIN_SELECT: sel_d  = reg_wdata[17:0];
            `REG_EVENT_EN:   en_d   = reg_wdata[17:0];
            `REG_POLARITY:   pol_d  = reg_wdata[17:0];
            `REG_DIRECTION:  dir_d  = reg_wdata[17:0];
            `REG_OUT_DATA:   dout_d = reg_wdata[17:0];
            `REG_LOCK_TIMER: tmr_d  = reg_wdata[7:0];
            default:         ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `CTRL_RESET;
         sel_q  <= `PINS_RESET;
         en_q   <= `PINS_RESET;
         pol_q  <= `POLARITY_RESET;
         dir_q  <= `PINS_RESET;
         dout_q <= `PINS_RESET;
         tmr_q  <= `TIMER_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         sel_q  <= sel_d;
         en_q   <= en_d;
         pol_q  <= pol_d;
         dir_q  <= dir_d;
         dout_q <= dout_d;
         tmr_q  <= tmr_d;
      end
   end

   // field widths cap the lock timers at their largest values
   assign unlock_time_s = tmr_q[2:0];
   assign mask_time_s   = tmr_q[7:3];

   ////////////////////////////////////////////////////////////////////////
   // plain input tracking

   logic [17:0] armed_q, armed_d;
   logic [17:0] plain_act;
   logic [17:0] plain_cand;
   logic        slot_free;
   logic        evt_valid_q;
   logic        plain_gated;

   assign slot_free = !evt_valid_q || event_ready;

   // a candidate differs from the level it is armed for
   always_comb begin
      plain_act  = ~(pin_lvl ^ pol_q);
      plain_cand = en_q & ~sel_q & ~dir_q & (plain_act ^ armed_q);
      if (!scan_en) plain_cand = '0;
      plain_idx   = first_set(plain_cand);
      take_plain  = (plain_cand != '0) && slot_free;
      plain_gated = keypad_locked && ctrl_q[`CTRL_EVENT_MODE];
      armed_d = armed_q;
      for (int i = 0; i < `PIN_COUNT; i++) begin
         if (!en_q[i] || sel_q[i] || dir_q[i] || !scan_en) begin
            armed_d[i] = plain_act[i];
         end
      end
      if (take_plain) begin
         armed_d[plain_idx] = plain_act[plain_idx];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) armed_q <= '0;
      else     armed_q <= armed_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // matrix scan sequencer

   keypad_pkg::scan_state_t      state_q, state_d;
   logic [3:0]                   col_d;
   logic [`SLOT_CNT_W-1:0]       cnt_q, cnt_d;
   logic [79:0]                  key_q, key_d;
   logic [7:0]                   row_hit;
   logic [7:0]                   row_cur;
   logic [7:0]                   row_chg;
   logic                         col_sel;
   logic [4:0]                   row_pick;

   // compare the driven column against remembered key states
   always_comb begin
      col_sel = sel_q[`COL_BASE + col_q];
      for (int r = 0; r < `NUM_ROWS; r++) begin
         row_cur[r] = key_q[r * `NUM_COLS + col_q];
         row_hit[r] = sel_q[r] && col_sel && !pin_lvl[r];
      end
      row_chg  = row_hit ^ row_cur;
      row_pick = first_set({10'h000, row_chg});
      key_row  = row_pick[2:0];
      take_key = (state_q == keypad_pkg::SCAN_SAMPLE) && (row_chg != '0)
                 && slot_free && !take_plain;
      press_w  = take_plain ? plain_act[plain_idx] : row_hit[key_row];
   end

   // step through columns; one slot of settling per selected column, unselected columns skipped in one cycle
   always_comb begin
      state_d = state_q;
      col_d   = col_q;
      cnt_d   = cnt_q;
      key_d   = key_q;
      unique case (state_q)
         keypad_pkg::SCAN_IDLE: begin
            col_d = '0;
            cnt_d = SLOT_LAST;
            if (scan_en) state_d = keypad_pkg::SCAN_SETTLE;
         end
         keypad_pkg::SCAN_SETTLE: begin
            if (!col_sel || cnt_q == '0) begin
               state_d = col_sel ? keypad_pkg::SCAN_SAMPLE
                                 : keypad_pkg::SCAN_SETTLE;
               if (!col_sel) begin
                  col_d = (col_q == 4'(`NUM_COLS - 1)) ? '0 : col_q + 4'h1;
                  cnt_d = SLOT_LAST;
               end
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         keypad_pkg::SCAN_SAMPLE: begin
            if (take_key) begin
               key_d[key_row * `NUM_COLS + col_q] = row_hit[key_row];
            end else if (row_chg == '0) begin
               state_d = keypad_pkg::SCAN_SETTLE;
               col_d = (col_q == 4'(`NUM_COLS - 1)) ? '0 : col_q + 4'h1;
               cnt_d = SLOT_LAST;
            end
         end
         default: state_d = keypad_pkg::SCAN_IDLE;
      endcase
      if (!scan_en) begin
         state_d = keypad_pkg::SCAN_IDLE;
         key_d   = '0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= keypad_pkg::SCAN_IDLE;
         col_q   <= '0;
         cnt_q   <= '0;
         key_q   <= '0;
      end else begin
         state_q <= state_d;
         col_q   <= col_d;
         cnt_q   <= cnt_d;
         key_q   <= key_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event output, pin drive and register read data

   logic [7:0]  code_q, code_d;
   logic        evt_valid_d;
   logic        from_in_q, from_in_d;
   logic        unl_q, unl_d;
   logic [15:0] count_q, count_d;
   logic [17:0] out_q, out_d;
   logic [17:0] oe_q, oe_d;
   logic [31:0] rdata_q, rdata_d;
   logic        queue_it;

   always_comb begin
      queue_it    = take_key || (take_plain && !plain_gated);
      evt_valid_d = evt_valid_q && !event_ready;
      code_d      = code_q;
      from_in_d   = from_in_q;
      count_d     = count_q;
      unl_d       = take_key || take_plain;
      if (take_key || take_plain) code_d = code_w;
      if (queue_it) begin
         evt_valid_d = 1'b1;
         from_in_d   = take_plain;
         count_d     = count_q + 16'h0001;
      end
      // matrix column low in its slot, outputs drive their data
      for (int p = 0; p < `PIN_COUNT; p++) begin
         oe_d[p]  = dir_q[p] && !sel_q[p];
         out_d[p] = dout_q[p];
      end
      for (int c = 0; c < `NUM_COLS; c++) begin
         if (sel_q[`COL_BASE + c] && state_q != keypad_pkg::SCAN_IDLE &&
             col_q == 4'(c)) begin
            oe_d[`COL_BASE + c]  = 1'b1;
            out_d[`COL_BASE + c] = 1'b0;
         end
      end
      rdata_d = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            `REG_CTRL:        rdata_d = {30'h0, ctrl_q};
            `REG_PIN_SELECT:  rdata_d = {14'h0, sel_q};
            `REG_EVENT_EN:    rdata_d = {14'h0, en_q};
            `REG_POLARITY:    rdata_d = {14'h0, pol_q};
            `REG_DIRECTION:   rdata_d = {14'h0, dir_q};
            `REG_OUT_DATA:    rdata_d = {14'h0, dout_q};
            `REG_PIN_LEVEL:   rdata_d = {14'h0, pin_lvl};
            `REG_EVENT_COUNT: rdata_d = {16'h0, count_q};
            `REG_LAST_EVENT:  rdata_d = {24'h0, code_q};
            `REG_LOCK_TIMER:  rdata_d = {24'h0, tmr_q};
            default:          rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         evt_valid_q <= 1'b0;
         code_q      <= '0;
         from_in_q   <= 1'b0;
         unl_q       <= 1'b0;
         count_q     <= '0;
         out_q       <= '0;
         oe_q        <= '0;
         rdata_q     <= '0;
      end else begin
         evt_valid_q <= evt_valid_d;
         code_q      <= code_d;
         from_in_q   <= from_in_d;
         unl_q       <= unl_d;
         count_q     <= count_d;
         out_q       <= out_d;
         oe_q        <= oe_d;
         rdata_q     <= rdata_d;
      end
   end

   assign event_valid      = evt_valid_q;
   assign event_code       = code_q;
   assign event_from_input = from_in_q;
   assign unlock_valid     = unl_q;
   assign pin_out          = out_q;
   assign pin_oe           = oe_q;
   assign reg_rdata        = rdata_q;

endmodule : keypad_event_encoder

// ==== rtl/keypad_cfg.svh ====
// keypad_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name into files that compile after it
`ifndef KEYPAD_CFG_SVH
`define KEYPAD_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// pin layout: rows are pins 0..7, columns are pins 8..17
`define NUM_ROWS         8
`define NUM_COLS         10
`define PIN_COUNT        18
`define COL_BASE         8

// event codes
`define MATRIX_CODE_BASE 7'h01
`define ROW_INPUT_BASE   7'h61
`define COL_INPUT_BASE   7'h69
`define PRESS_BIT        7

////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define REG_CTRL         8'h00
`define REG_PIN_SELECT   8'h04
`define REG_EVENT_EN     8'h08
`define REG_POLARITY     8'h0c
`define REG_DIRECTION    8'h10
`define REG_OUT_DATA     8'h14
`define REG_PIN_LEVEL    8'h18
`define REG_EVENT_COUNT  8'h1c
`define REG_LAST_EVENT   8'h20
`define REG_LOCK_TIMER   8'h24

// control fields and reset values
`define CTRL_SCAN_EN     0
`define CTRL_EVENT_MODE  1
`define CTRL_RESET       2'h0
`define PINS_RESET       18'h00000
`define POLARITY_RESET   18'h00000
`define TIMER_RESET      8'h00

////////////////////////////////////////////////////////////////////////////
// timing
`define SYS_CLK_MHZ      50
`define DETECT_LIMIT_US  25
`define UNLOCK_MAX_S     7
`define MASK_MAX_S       31
// two full scans plus five slots of slack stay inside the detection limit
`define SCAN_SLOT_CYC ((`DETECT_LIMIT_US*`SYS_CLK_MHZ)/(2*`NUM_COLS+5))
`define SLOT_CNT_W       8

`endif

// ==== rtl/keypad_pkg.sv ====
// keypad_pkg: types shared by the keypad event encoder
// assumes: nothing; compiled before all modules
package keypad_pkg;

   // matrix scan sequencer states
   typedef enum logic [1:0] {
      SCAN_IDLE   = 2'b00,
      SCAN_SETTLE = 2'b01,
      SCAN_SAMPLE = 2'b10
   } scan_state_t;

endpackage : keypad_pkg

// ==== rtl/pin_sync.sv ====
// pin_sync: two flip-flop synchroniser for a vector of pin inputs
// assumes: pins are asynchronous to sys_clk, each bit crosses on its own
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned WIDTH = 18
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // first stage is read only by the second stage
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // both stages reset to zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule : pin_sync

// ==== rtl/key_code_encoder.sv ====
// key_code_encoder: forms the event byte for a matrix key or plain input
// assumes: inputs are stable in the cycle they are used, pure logic
`timescale 1ns/1ps
`include "keypad_cfg.svh"
module key_code_encoder (
   input  wire logic       from_input,
   input  wire logic [4:0] pin_idx,
   input  wire logic [2:0] row,
   input  wire logic [3:0] col,
   input  wire logic       press,
   output logic      [7:0] code
);

   logic [6:0] value;

   // select the numbering by source type
   always_comb begin
      if (from_input && pin_idx < 5'(`COL_BASE)) begin
         value = 7'(`ROW_INPUT_BASE + pin_idx);
      end else if (from_input) begin
         value = 7'(`COL_INPUT_BASE + pin_idx - `COL_BASE);
      end else begin
         value = 7'(row * `NUM_COLS + col + `MATRIX_CODE_BASE);
      end
      code = {press, value};
   end

endmodule : key_code_encoder

// ==== testbench/keypad_event_checker_sva.sv ====
// keypad_event_checker_sva: port-level assertions for the event encoder
// assumes: bound to every keypad_event_encoder, one clock, rst async high
`timescale 1ns/1ps
`include "keypad_cfg.svh"
module keypad_event_checker #(
   parameter int unsigned SLOT_CYC = 50
) (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        keypad_locked,
   input wire logic        event_ready,
   input wire logic        event_valid,
   input wire logic [7:0]  event_code,
   input wire logic        event_from_input,
   input wire logic        unlock_valid,
   input wire logic [2:0]  unlock_time_s,
   input wire logic [4:0]  mask_time_s
);
   logic [1:0] ctrl_q, ctrl_d;
   logic [3:0] off_q, off_d;
   logic [7:0] wd_q, wd_d;
   ////////////////////////////////////////////////////////////////////////
   // shadow of control bits and a count of cycles with scanning off
   always_comb begin
      ctrl_d = (reg_wr && reg_addr == `REG_CTRL) ? reg_wdata[1:0] : ctrl_q;
      off_d  = ctrl_q[0] ? 4'h0 : ((off_q == 4'h8) ? off_q : off_q + 4'h1);
      wd_d   = reg_wdata[7:0];
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 2'h0;
         off_q  <= 4'h0;
         wd_q   <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         off_q  <= off_d;
         wd_q   <= wd_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_stall; event_valid && !event_ready; endsequence
   sequence s_timer_wr; reg_wr && reg_addr == `REG_LOCK_TIMER; endsequence
   sequence s_new_input; $rose(event_valid) && event_from_input; endsequence

   a_stall_hold: assert property (s_stall |=> event_valid &&
      $stable(event_code) && $stable(event_from_input))
      else $error("event changed while stalled");
   a_input_code: assert property (event_valid && event_from_input
      |-> event_code[6:0] inside {[7'h61:7'h72]})
      else $error("plain input code out of range");
   a_matrix_code: assert property (event_valid && !event_from_input
      |-> event_code[6:0] inside {[7'h01:7'h50]})
      else $error("matrix code out of range");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_timer_fields: assert property (s_timer_wr |=>
      unlock_time_s == wd_q[2:0] && mask_time_s == wd_q[7:3])
      else $error("timer fields not taken");
   a_rise_unlock: assert property ($rose(event_valid) |-> unlock_valid)
      else $error("event without unlock pulse");
   a_scan_off: assert property (off_q == 4'h8 |-> !$rose(event_valid))
      else $error("event while scanning off");
   a_lock_drop: assert property (s_new_input |->
      !(keypad_locked && $past(keypad_locked, 4) && ctrl_q[1]))
      else $error("plain event queued while locked");
endmodule : keypad_event_checker

bind keypad_event_encoder keypad_event_checker #(.SLOT_CYC(SLOT_CYC)) chk_i (
   .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .keypad_locked(keypad_locked), .event_ready(event_ready),
   .event_valid(event_valid), .event_code(event_code),
   .event_from_input(event_from_input), .unlock_valid(unlock_valid),
   .unlock_time_s(unlock_time_s), .mask_time_s(mask_time_s));

// ==== testbench/keypad_matrix_model.sv ====
// keypad_matrix_model: switch matrix plus discrete buttons on 18 pins
// assumes: rows 0..7 and columns 8..17, every pin pulled up outside
`timescale 1ns/1ps
module keypad_matrix_model (
   input  wire logic [17:0] pin_out,
   input  wire logic [17:0] pin_oe,
   input  wire logic [79:0] key_down,
   input  wire logic [17:0] plain_mask,
   input  wire logic [17:0] plain_level,
   output logic      [17:0] pin_in
);
   ////////////////////////////////////////////////////////////////////////
   // pull-ups, driven pins, closed switches, then discrete buttons
   always_comb begin
      pin_in = 18'h3ffff;
      for (int i = 0; i < 18; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
      end
      for (int r = 0; r < 8; r++) begin
         for (int c = 0; c < 10; c++) begin
            if (key_down[r*10+c] && pin_oe[8+c] && !pin_out[8+c])
               pin_in[r] = 1'b0;
         end
      end
      for (int i = 0; i < 18; i++) begin
         if (plain_mask[i]) pin_in[i] = plain_level[i];
      end
   end
endmodule : keypad_matrix_model

// ==== testbench/keypad_event_encoder_tb.sv ====
// keypad_event_encoder_tb: self-checking bench for the event encoder
// assumes: design, package, header, model and checker compiled before
`timescale 1ns/1ps
`include "keypad_cfg.svh"
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin \
   miscompares++; $display("CHECK FAILED %0t %s", $time, m); end end
module keypad_event_encoder_tb;
   logic        sys_clk, rst, reg_wr, reg_rd, keypad_locked, event_ready;
   logic [7:0]  reg_addr, event_code;
   logic [31:0] reg_wdata, reg_rdata, wd, rd_tmp;
   logic [17:0] pin_in, pin_out, pin_oe, plain_mask, plain_level, pol;
   logic [17:0] dir_v, dout_v;
   logic        event_valid, event_from_input, unlock_valid;
   logic [2:0]  unlock_time_s;
   logic [4:0]  mask_time_s;
   logic [79:0] key_down;
   logic [8:0]  exp_ev[$];
   logic [31:0] exp_rd[$];
   logic [8:0]  ev_tmp;
   logic        rd_seen = 1'b0;
   int          seed = 51655;
   int          miscompares = 0;
   int          check_count = 0;
   int          unlock_cnt = 0;
   int          n, r, c;

   keypad_event_encoder #(.SLOT_CYC(6)) keypad_event_encoder_i (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .keypad_locked(keypad_locked),
      .event_ready(event_ready), .event_valid(event_valid),
      .event_code(event_code), .event_from_input(event_from_input),
      .unlock_valid(unlock_valid), .unlock_time_s(unlock_time_s),
      .mask_time_s(mask_time_s));
   keypad_matrix_model keypad_matrix_model_i (
      .pin_out(pin_out), .pin_oe(pin_oe), .key_down(key_down),
      .plain_mask(plain_mask), .plain_level(plain_level), .pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////////
   // clock, random queue readiness, watchdog
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) event_ready <= 1'($random(seed));
   initial begin
      repeat (60000) @(posedge sys_clk);
      miscompares++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      summarize();
   end
   ////////////////////////////////////////////////////////////////////////
   // watcher: compares read data and accepted events with oldest notes
   always @(posedge sys_clk) begin
      rd_seen <= reg_rd;
      if (unlock_valid === 1'b1) unlock_cnt++;
      if (rd_seen === 1'b1) begin
         rd_tmp = exp_rd.pop_front();
         `CHK(reg_rdata, rd_tmp, "read data")
      end
      if (event_valid === 1'b1 && event_ready === 1'b1) begin
         ev_tmp = exp_ev.pop_front();
         `CHK({event_from_input, event_code}, ev_tmp, "event")
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      @(posedge sys_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask : reg_read
   task automatic drain(input int lim);
      int k;
      k = 0;
      while (exp_ev.size() > 0 && k < lim) begin
         @(posedge sys_clk);
         k++;
      end
      repeat (40) @(posedge sys_clk);
      `CHK(exp_ev.size(), 0, "event missing or late")
   endtask : drain
   // press then release one plain input pin, with or without events
   task automatic plain_cycle(input int i, input bit tracked);
      logic [6:0] code;
      code = (i < 8) ? 7'(97 + i) : 7'(105 + i - 8);
      if (tracked) exp_ev.push_back({2'b11, code});
      @(posedge sys_clk);
      plain_level[i] <= pol[i];
      drain(100);
      if (tracked) exp_ev.push_back({2'b10, code});
      @(posedge sys_clk);
      plain_level[i] <= ~pol[i];
      drain(100);
   endtask : plain_cycle
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
      reg_wdata = 32'h0; keypad_locked = 1'b0;
      key_down = 80'h0; plain_mask = 18'h3ffff; pol = 18'($random(seed));
      plain_level = ~pol;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      reg_read(`REG_CTRL, 32'h0);
      reg_read(`REG_PIN_SELECT, 32'h0);
      reg_read(`REG_EVENT_EN, 32'h0);
      reg_read(`REG_LOCK_TIMER, 32'h0);
      reg_read(8'h3c, 32'h0);
      wd = $random(seed);
      reg_write(`REG_LOCK_TIMER, wd);
      reg_read(`REG_LOCK_TIMER, {24'h0, wd[7:0]});
      `CHK(unlock_time_s, wd[2:0], "unlock time")
      `CHK(mask_time_s, wd[7:3], "mask time")
      // every pin as plain input except pin 0, which stays unenrolled
      reg_write(`REG_POLARITY, {14'h0, pol});
      reg_write(`REG_EVENT_EN, 32'h3fffe);
      reg_write(`REG_CTRL, 32'h1);
      for (int i = 0; i < 18; i++) plain_cycle(i, i != 0);
      // locked: mode bit set drops plain events, clear keeps them
      keypad_locked <= 1'b1;
      reg_write(`REG_CTRL, 32'h3);
      n = unlock_cnt;
      plain_cycle(1, 1'b0);
      `CHK(unlock_cnt - n, 2, "unlock pulses")
      reg_write(`REG_CTRL, 32'h1);
      plain_cycle(9, 1'b1);
      keypad_locked <= 1'b0;
      // full 8 by 10 matrix, corner keys then random keys
      plain_mask <= 18'h0;
      reg_write(`REG_EVENT_EN, 32'h0);
      reg_write(`REG_PIN_SELECT, 32'h3ffff);
      for (int k = 0; k < 8; k++) begin
         r = (k < 2) ? 7 * k : $unsigned($random(seed)) % 8;
         c = (k < 2) ? 9 * k : $unsigned($random(seed)) % 10;
         exp_ev.push_back({2'b01, 7'(10 * r + c + 1)});
         @(posedge sys_clk);
         key_down[10*r+c] <= 1'b1;
         drain(400);
         exp_ev.push_back({2'b00, 7'(10 * r + c + 1)});
         @(posedge sys_clk);
         key_down <= 80'h0;
         drain(400);
      end
      // scan off: an enrolled plain input makes no event
      reg_write(`REG_CTRL, 32'h0);
      reg_write(`REG_PIN_SELECT, 32'h0);
      reg_write(`REG_EVENT_EN, 32'h3ffff);
      plain_mask <= 18'h00008;
      plain_cycle(3, 1'b0);
      plain_mask <= 18'h0;
      // output pins drive their data, seen back on the pins
      dir_v = 18'($random(seed));
      dout_v = 18'($random(seed));
      reg_write(`REG_DIRECTION, {14'h0, dir_v});
      reg_write(`REG_OUT_DATA, {14'h0, dout_v});
      repeat (4) @(posedge sys_clk);
      `CHK(pin_oe, dir_v, "pin drive enable")
      `CHK(pin_out, dout_v, "pin drive value")
      reg_read(`REG_PIN_LEVEL, {14'h0, ~dir_v | dout_v});
      reg_read(`REG_EVENT_COUNT, 32'h34);
      reg_read(`REG_LAST_EVENT, {24'h0, 1'b0, 7'(10*r+c+1)});
      repeat (2) @(posedge sys_clk);
      summarize();
   end
endmodule : keypad_event_encoder_tb
